// File: core/pcc_map.vh
// Register offsets, bit positions, reset values and bus codes of the command bank.
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// ==========================================================================
// Register offsets
// ==========================================================================
`define PCC_ADDR_W          8
`define PCC_DATA_W          16
`define PCC_OFF_COMMAND     8'h04
`define PCC_OFF_STATUS      8'h06

// ==========================================================================
// Command register bit positions
// ==========================================================================
`define PCC_CMD_IO_SPACE    0
`define PCC_CMD_MEM_SPACE   1
`define PCC_CMD_BUS_MASTER  2
`define PCC_CMD_SPECIAL     3
`define PCC_CMD_WR_INVAL    4
`define PCC_CMD_PALETTE     5
`define PCC_CMD_PAR_RESP    6
`define PCC_CMD_STEPPING    7
`define PCC_CMD_SYS_ERR     8
`define PCC_CMD_FAST_B2B    9

// ==========================================================================
// Status register bit positions
// ==========================================================================
`define PCC_STS_DET_PAR     15

// ==========================================================================
// Reset values
// ==========================================================================
`define PCC_RST_BIT0        1'h0
`define PCC_RST_STEP_ON     1'h1
`define PCC_RST_RDATA       16'h0000

// ==========================================================================
// Bus command codes driven on the byte-enable lines
// ==========================================================================
`define PCC_BUSCMD_W        4
`define PCC_BUSCMD_MEM_WR   4'h7
`define PCC_BUSCMD_MWI      4'hF

// ==========================================================================
// Bus widths
// ==========================================================================
`define PCC_AD_W            32
`define PCC_CBE_W           4

`endif

// File: core/pcc_par_gen.v
// Even parity generator over the address/data and byte-enable lines.
`timescale 1ns/1ps
`include "pcc_map.vh"

module pcc_par_gen #(
    parameter AD_W  = `PCC_AD_W,
    parameter CBE_W = `PCC_CBE_W
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // Lines driven in the current data phase
    input  wire [AD_W-1:0]  ad_out,
    input  wire [CBE_W-1:0] cbe_out,
    input  wire             ad_drive,
    // Parity one clock later
    output wire             par_o,
    output wire             par_oe
);

    reg par_r;
    reg par_oe_r;

    // Parity follows the data phase by one clock, as the bus expects.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            par_r    <= `PCC_RST_BIT0;
            par_oe_r <= `PCC_RST_BIT0;
        end else begin
            par_r    <= (^ad_out) ^ (^cbe_out);
            par_oe_r <= ad_drive;
        end
    end

    assign par_o  = par_r;
    assign par_oe = par_oe_r;

endmodule // pcc_par_gen

// File: core/pcc_cmd_ctrl.v
// Command register control bits and their effect on target and master activity.
// Notes on behaviour
// (R1) A device that never steps keeps the stepping bit at 7 cleared.
// (R2) A device able to step or not makes it read/write, reset 1.
// (R3) Parity response bit 6 set: normal parity error handling on detection.
// (R4) Response bit 0: set detected parity flag, no PERR#, keep running.
// (R5) Parity response bit reads 0 after reset; implemented since parity is checked.
// (R6) Parity is always generated on driven transfers, even with checking off.
// (R7) Palette snoop bit 5: 0 respond normally, 1 ignore writes and snoop.
// (R8) Write-invalidate bit 4: 0 plain memory writes, 1 may use MWI; resets 0.
// (R9) A master able to issue MWI implements the write-invalidate bit.
// (R10) Special cycle bit 3: 0 ignore special cycles, 1 may monitor; resets 0.
// (R11) Bus master bit 2: 0 never initiate accesses, 1 may master; resets 0.
// (R12) Command all zero: answer only configuration accesses.
// (R13) Status register is read-only and records bus events, parity flag included.
// (R14) Written bits take effect from the next bus transaction after the write.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "pcc_map.vh"

module pcc_cmd_ctrl #(
    parameter STEP_EITHER    = 0,
    parameter PALETTE_CAP    = 0,
    parameter SPECIAL_CAP    = 0,
    parameter AD_W           = `PCC_AD_W,
    parameter CBE_W          = `PCC_CBE_W
) (
    // Clock and reset
    input  wire                   ref_clk,
    input  wire                   rst_n,
    // Configuration register port
    input  wire [`PCC_ADDR_W-1:0] reg_addr,
    input  wire [`PCC_DATA_W-1:0] reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output wire [`PCC_DATA_W-1:0] reg_rdata,
    // Bus transaction framing
    input  wire                   bus_busy,
    // Target decode requests
    input  wire                   tgt_cfg_hit,
    input  wire                   tgt_mem_hit,
    input  wire                   tgt_io_hit,
    input  wire                   tgt_palette_wr,
    input  wire [AD_W-1:0]        tgt_wdata,
    output wire                   tgt_claim,
    output wire                   palette_snoop_valid,
    output wire [AD_W-1:0]        palette_snoop_data,
    // Special cycle broadcast
    input  wire                   special_seen,
    input  wire [AD_W-1:0]        special_msg,
    output wire                   special_valid,
    output wire [AD_W-1:0]        special_data,
    // Master requests from the host controller cores
    input  wire                   mst_req,
    input  wire                   mst_line_write,
    input  wire                   mst_write,
    output wire                   mst_go,
    output wire [CBE_W-1:0]       mst_cmd,
    // Parity check result and error pin
    input  wire                   par_err_det,
    output wire                   perr_o,
    output wire                   perr_oe,
    // Parity generation for driven phases
    input  wire [AD_W-1:0]        ad_out,
    input  wire [CBE_W-1:0]       cbe_out,
    input  wire                   ad_drive,
    output wire                   par_o,
    output wire                   par_oe,
    // Live control bits
    output wire                   stepping_control,
    output wire                   parity_error_response,
    output wire                   write_invalidate_enable,
    output wire                   bus_master_enable
);

    // ======================================================================
    // Software copy of the command register
    // ======================================================================
    reg  step_r;
    reg  per_r;
    reg  snoop_r;
    reg  wie_r;
    reg  scm_r;
    reg  bme_r;
    reg  mem_r;
    reg  io_r;
    reg  serr_r;
    reg  fbb_r;
    wire cmd_wr;

    assign cmd_wr = reg_wr && (reg_addr == `PCC_OFF_COMMAND);

    // Writable bits load from the port; fixed bits stay at their tie value.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            // (R2) stepping reset value
            step_r  <= (STEP_EITHER != 0) ? `PCC_RST_STEP_ON : `PCC_RST_BIT0;
            // (R5) response bit clear
            per_r   <= `PCC_RST_BIT0;
            snoop_r <= `PCC_RST_BIT0;
            wie_r   <= `PCC_RST_BIT0;
            scm_r   <= `PCC_RST_BIT0;
            bme_r   <= `PCC_RST_BIT0;
            mem_r   <= `PCC_RST_BIT0;
            io_r    <= `PCC_RST_BIT0;
            serr_r  <= `PCC_RST_BIT0;
            fbb_r   <= `PCC_RST_BIT0;
        end else if (cmd_wr) begin
            // (R1) never-step tie off
            step_r  <= (STEP_EITHER != 0) ? reg_wdata[`PCC_CMD_STEPPING] : `PCC_RST_BIT0;
            per_r   <= reg_wdata[`PCC_CMD_PAR_RESP];
            // (R7) palette bit storage
            snoop_r <= (PALETTE_CAP != 0) ? reg_wdata[`PCC_CMD_PALETTE] : `PCC_RST_BIT0;
            // (R9) write-invalidate storage
            wie_r   <= reg_wdata[`PCC_CMD_WR_INVAL];
            scm_r   <= (SPECIAL_CAP != 0) ? reg_wdata[`PCC_CMD_SPECIAL] : `PCC_RST_BIT0;
            bme_r   <= reg_wdata[`PCC_CMD_BUS_MASTER];
            mem_r   <= reg_wdata[`PCC_CMD_MEM_SPACE];
            io_r    <= reg_wdata[`PCC_CMD_IO_SPACE];
            serr_r  <= reg_wdata[`PCC_CMD_SYS_ERR];
            fbb_r   <= reg_wdata[`PCC_CMD_FAST_B2B];
        end
    end

    // ======================================================================
    // Bits in force on the bus
    // ======================================================================
    reg act_step_r;
    reg act_per_r;
    reg act_snoop_r;
    reg act_wie_r;
    reg act_scm_r;
    reg act_bme_r;
    reg act_mem_r;
    reg act_io_r;

    // (R14) apply between transactions
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            act_step_r  <= (STEP_EITHER != 0) ? `PCC_RST_STEP_ON : `PCC_RST_BIT0;
            act_per_r   <= `PCC_RST_BIT0;
            act_snoop_r <= `PCC_RST_BIT0;
            act_wie_r   <= `PCC_RST_BIT0;
            act_scm_r   <= `PCC_RST_BIT0;
            act_bme_r   <= `PCC_RST_BIT0;
            act_mem_r   <= `PCC_RST_BIT0;
            act_io_r    <= `PCC_RST_BIT0;
        end else if (!bus_busy) begin
            act_step_r  <= step_r;
            act_per_r   <= per_r;
            act_snoop_r <= snoop_r;
            act_wie_r   <= wie_r;
            act_scm_r   <= scm_r;
            act_bme_r   <= bme_r;
            act_mem_r   <= mem_r;
            act_io_r    <= io_r;
        end
    end

    assign stepping_control        = act_step_r;
    assign parity_error_response   = act_per_r;
    assign write_invalidate_enable = act_wie_r;
    assign bus_master_enable       = act_bme_r;

    // ======================================================================
    // Target response
    // ======================================================================
    // (R12) config always answered
    // (R7) palette writes not claimed while snooping
    assign tgt_claim = tgt_cfg_hit
                     || (tgt_mem_hit && act_mem_r && !(tgt_palette_wr && act_snoop_r))
                     || (tgt_io_hit && act_io_r && !(tgt_palette_wr && act_snoop_r));

    reg            snp_vld_r;
    reg [AD_W-1:0] snp_dat_r;

    // (R7) snoop palette data
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            snp_vld_r <= `PCC_RST_BIT0;
            snp_dat_r <= {AD_W{1'b0}};
        end else begin
            snp_vld_r <= tgt_palette_wr && act_snoop_r;
            if (tgt_palette_wr && act_snoop_r) begin
                snp_dat_r <= tgt_wdata;
            end
        end
    end

    assign palette_snoop_valid = snp_vld_r;
    assign palette_snoop_data  = snp_dat_r;

    // ======================================================================
    // Special cycle monitor
    // ======================================================================
    reg            sc_vld_r;
    reg [AD_W-1:0] sc_dat_r;

    // (R10) ignore unless enabled
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sc_vld_r <= `PCC_RST_BIT0;
            sc_dat_r <= {AD_W{1'b0}};
        end else begin
            sc_vld_r <= special_seen && act_scm_r;
            if (special_seen && act_scm_r) begin
                sc_dat_r <= special_msg;
            end
        end
    end

    assign special_valid = sc_vld_r;
    assign special_data  = sc_dat_r;

    // ======================================================================
    // Master request gate and write command choice
    // ======================================================================
    // (R11) no access without master enable
    assign mst_go = mst_req && act_bme_r;

    reg [CBE_W-1:0] mst_cmd_r;

    // (R8) MWI only when enabled
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            mst_cmd_r <= `PCC_BUSCMD_MEM_WR;
        end else if (mst_req && mst_write) begin
            mst_cmd_r <= (act_wie_r && mst_line_write) ? `PCC_BUSCMD_MWI
                                                       : `PCC_BUSCMD_MEM_WR;
        end
    end

    assign mst_cmd = mst_cmd_r;

    // ======================================================================
    // Parity error handling
    // ======================================================================
    reg perr_r;
    reg det_par_r;

    // (R3) assert error pin when responding
    // (R4) flag always, pin only when enabled
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            perr_r    <= `PCC_RST_BIT0;
            det_par_r <= `PCC_RST_BIT0;
        end else begin
            perr_r <= par_err_det && act_per_r;
            if (par_err_det) begin
                det_par_r <= 1'b1;
            end
        end
    end

    // Open-drain pin: drive low only while reporting.
    assign perr_o  = 1'b0;
    assign perr_oe = perr_r;

    // (R6) parity always generated
    pcc_par_gen #(
        .AD_W  (AD_W),
        .CBE_W (CBE_W)
    ) u_par_gen (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ad_out  (ad_out),
        .cbe_out (cbe_out),
        .ad_drive(ad_drive),
        .par_o   (par_o),
        .par_oe  (par_oe)
    );

    // ======================================================================
    // Register read
    // ======================================================================
    reg [`PCC_DATA_W-1:0] rd_val;
    reg [`PCC_DATA_W-1:0] rdata_r;

    // Assemble the addressed word; unmapped offsets read zero.
    always @* begin
        rd_val = {`PCC_DATA_W{1'b0}};
        case (reg_addr)
            `PCC_OFF_COMMAND: begin
                rd_val[`PCC_CMD_IO_SPACE]   = io_r;
                rd_val[`PCC_CMD_MEM_SPACE]  = mem_r;
                rd_val[`PCC_CMD_BUS_MASTER] = bme_r;
                rd_val[`PCC_CMD_SPECIAL]    = scm_r;
                rd_val[`PCC_CMD_WR_INVAL]   = wie_r;
                rd_val[`PCC_CMD_PALETTE]    = snoop_r;
                rd_val[`PCC_CMD_PAR_RESP]   = per_r;
                rd_val[`PCC_CMD_STEPPING]   = step_r;
                rd_val[`PCC_CMD_SYS_ERR]    = serr_r;
                rd_val[`PCC_CMD_FAST_B2B]   = fbb_r;
            end
            // (R13) read-only status
            `PCC_OFF_STATUS: begin
                rd_val[`PCC_STS_DET_PAR] = det_par_r;
            end
            default: begin
                rd_val = {`PCC_DATA_W{1'b0}};
            end
        endcase
    end

    // Read data stand in the cycle after the strobe only.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r <= `PCC_RST_RDATA;
        end else if (reg_rd) begin
            rdata_r <= rd_val;
        end else begin
            rdata_r <= `PCC_RST_RDATA;
        end
    end

    assign reg_rdata = rdata_r;

endmodule // pcc_cmd_ctrl

// File: tb/pcc_host_model.sv
// Configuration host model that drives the command bank register port.
`timescale 1ns/1ps
`include "pcc_map.vh"

module pcc_host_model (
    // Clock
    input  wire                    ref_clk,
    // Register port
    output logic [`PCC_ADDR_W-1:0] reg_addr,
    output logic [`PCC_DATA_W-1:0] reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire  [`PCC_DATA_W-1:0] reg_rdata
);
    // ======================================================================
    // Bus cycles
    // ======================================================================
    // Idle port at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // Stale data is not left on the port.
    endtask

    // One-cycle read; the data stand only in the following cycle.
    task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // pcc_host_model

// File: tb/pcc_cmd_ctrl_sva.sv
// Concurrent checks on the ports of the command bank.
`timescale 1ns/1ps
`include "pcc_map.vh"

module pcc_cmd_ctrl_sva #(
    parameter STEP_EITHER = 0
) (
    // Clock, reset and register port
    input wire ref_clk, rst_n, reg_wr, reg_rd, bus_busy,
    input wire [`PCC_ADDR_W-1:0] reg_addr,
    input wire [`PCC_DATA_W-1:0] reg_wdata, reg_rdata,
    // Target, master and parity
    input wire tgt_cfg_hit, tgt_claim, mst_req, mst_write, mst_line_write, mst_go,
    input wire [`PCC_CBE_W-1:0] mst_cmd, cbe_out,
    input wire par_err_det, perr_o, perr_oe, ad_drive, par_o, par_oe,
    input wire [`PCC_AD_W-1:0] ad_out,
    // Live control bits
    input wire stepping_control, parity_error_response,
    input wire write_invalidate_enable, bus_master_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ======================================================================
    // Properties
    // ======================================================================
    sequence s_bm_set;
        reg_wr && reg_addr == 8'h04 && reg_wdata[2];
    endsequence
    sequence s_mwi_req;
        mst_req && mst_write && write_invalidate_enable && mst_line_write;
    endsequence
    property p_fixed7; reg_rd && reg_addr == 8'h04 && STEP_EITHER == 0 |=> !reg_rdata[7];
    endproperty
    property p_step; STEP_EITHER == 0 |-> !stepping_control; endproperty
    property p_go; mst_go == (mst_req && bus_master_enable); endproperty
    property p_perr_on; par_err_det && parity_error_response |=> perr_oe; endproperty
    property p_perr_off;
        !(par_err_det && parity_error_response) |=> !perr_oe && !perr_o;
    endproperty
    property p_par;
        ad_drive |=> par_oe && (par_o == (^$past(ad_out) ^ ^$past(cbe_out)));
    endproperty
    property p_mwi; s_mwi_req |=> mst_cmd == 4'hF; endproperty
    property p_plain;
        mst_req && mst_write && !(write_invalidate_enable && mst_line_write)
            |=> mst_cmd == 4'h7;
    endproperty
    property p_cfg; tgt_cfg_hit |-> tgt_claim; endproperty
    property p_apply; s_bm_set ##1 !bus_busy |=> bus_master_enable; endproperty

    a_fixed7: assert property (p_fixed7) else $error("stepping bit read back set");
    a_step: assert property (p_step) else $error("stepping bit active");
    a_go: assert property (p_go) else $error("master grant mismatch");
    a_perr_on: assert property (p_perr_on) else $error("error pin not driven");
    a_perr_off: assert property (p_perr_off) else $error("error pin driven");
    a_par: assert property (p_par) else $error("bus parity wrong");
    a_mwi: assert property (p_mwi) else $error("invalidate command missing");
    a_plain: assert property (p_plain) else $error("plain write command missing");
    a_cfg: assert property (p_cfg) else $error("config access not claimed");
    a_apply: assert property (p_apply) else $error("master bit not applied");
endmodule // pcc_cmd_ctrl_sva

bind pcc_cmd_ctrl pcc_cmd_ctrl_sva #(.STEP_EITHER(STEP_EITHER)) i_sva (.ref_clk, .rst_n,
    .reg_wr, .reg_rd, .bus_busy, .reg_addr, .reg_wdata, .reg_rdata, .tgt_cfg_hit,
    .tgt_claim, .mst_req, .mst_write, .mst_line_write, .mst_go, .mst_cmd, .cbe_out,
    .par_err_det, .perr_o, .perr_oe, .ad_drive, .par_o, .par_oe, .ad_out,
    .stepping_control, .parity_error_response, .write_invalidate_enable,
    .bus_master_enable);

// File: tb/pci_command_ctrl_bits_test.sv
// Directed testbench of the command bank.
`timescale 1ns/1ps
`include "pcc_map.vh"
`define PCC_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end

module pci_command_ctrl_bits_test;
    logic        ref_clk, rst_n, bus_busy, tgt_cfg_hit, tgt_mem_hit, tgt_io_hit;
    logic        tgt_palette_wr, special_seen, mst_req, mst_line_write, mst_write;
    logic        par_err_det, ad_drive;
    logic [31:0] tgt_wdata, special_msg, ad_out, palette_snoop_data, special_data;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0]  reg_addr;
    logic [3:0]  cbe_out, mst_cmd;
    logic        reg_wr, reg_rd, tgt_claim, palette_snoop_valid, special_valid, mst_go;
    logic        perr_o, perr_oe, par_o, par_oe, stepping_control, parity_error_response;
    logic        write_invalidate_enable, bus_master_enable;
    int          fails = 0;
    int          total_checks = 0;

    pcc_host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    pcc_cmd_ctrl i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .bus_busy, .tgt_cfg_hit, .tgt_mem_hit, .tgt_io_hit, .tgt_palette_wr,
        .tgt_wdata, .tgt_claim, .palette_snoop_valid, .palette_snoop_data, .special_seen,
        .special_msg, .special_valid, .special_data, .mst_req, .mst_line_write, .mst_write,
        .mst_go, .mst_cmd, .par_err_det, .perr_o, .perr_oe, .ad_out, .cbe_out, .ad_drive,
        .par_o, .par_oe, .stepping_control, .parity_error_response,
        .write_invalidate_enable, .bus_master_enable);

    // ======================================================================
    // Helpers
    // ======================================================================
    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.cfg_read(a, d);
        `PCC_CHK(d, exp)
    endtask

    // One-cycle parity error pulse; the pin answer is looked at in the cycle after it.
    task automatic par_pulse;
        @(posedge ref_clk);
        par_err_det <= 1'b1;
        @(posedge ref_clk);
        par_err_det <= 1'b0;
        #1;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard well beyond the length of the directed sequence.
    initial begin
        #20000;
        fails++;
        complete_run();
    end

    // ======================================================================
    // Tests
    // ======================================================================
    // Directed sequence of register accesses and bus events.
    initial begin
        {bus_busy, tgt_cfg_hit, tgt_mem_hit, tgt_io_hit, tgt_palette_wr, special_seen} = '0;
        {mst_req, mst_line_write, mst_write, par_err_det, ad_drive, cbe_out} = '0;
        {tgt_wdata, special_msg, ad_out} = '0;
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(8'h04, 16'h0000);
        rd_chk(8'h06, 16'h0000);
        `PCC_CHK(stepping_control, 1'b0)
        `PCC_CHK(bus_master_enable, 1'b0)
        `PCC_CHK(parity_error_response, 1'b0)
        `PCC_CHK(write_invalidate_enable, 1'b0)
        $display("test reset values done");
        i_host.cfg_write(8'h04, 16'hFFFF);
        rd_chk(8'h04, 16'h0357);
        `PCC_CHK(stepping_control, 1'b0)
        `PCC_CHK(parity_error_response, 1'b1)
        `PCC_CHK(write_invalidate_enable, 1'b1)
        i_host.cfg_write(8'h06, 16'hFFFF);
        rd_chk(8'h06, 16'h0000);
        rd_chk(8'h10, 16'h0000);
        @(posedge ref_clk);
        {mst_req, mst_write, mst_line_write, tgt_mem_hit, tgt_io_hit, tgt_palette_wr} <= 6'h3F;
        {tgt_wdata, special_msg} <= {32'h0000_00A5, 32'h0000_005A};
        special_seen <= 1'b1;
        step(1);
        `PCC_CHK(mst_cmd, 4'hF)
        `PCC_CHK(mst_go, 1'b1)
        `PCC_CHK(tgt_claim, 1'b1)
        `PCC_CHK(palette_snoop_valid, 1'b0)
        `PCC_CHK(special_valid, 1'b0)
        `PCC_CHK(palette_snoop_data, 32'h0000_0000)
        `PCC_CHK(special_data, 32'h0000_0000)
        @(posedge ref_clk);
        special_seen <= 1'b0;
        par_pulse();
        `PCC_CHK(perr_oe, 1'b1)
        $display("test all bits set done");
        @(posedge ref_clk);
        bus_busy <= 1'b1;
        i_host.cfg_write(8'h04, 16'h0000);
        step(2);
        `PCC_CHK(mst_go, 1'b1)
        @(posedge ref_clk);
        bus_busy <= 1'b0;
        step(2);
        `PCC_CHK(mst_go, 1'b0)
        `PCC_CHK(mst_cmd, 4'h7)
        `PCC_CHK(tgt_claim, 1'b0)
        @(posedge ref_clk);
        tgt_cfg_hit <= 1'b1;
        step(1);
        `PCC_CHK(tgt_claim, 1'b1)
        rd_chk(8'h06, 16'h8000);
        // Mid-run reset clears the sticky flag so the next error is seen alone.
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(8'h06, 16'h0000);
        `PCC_CHK(tgt_claim, 1'b1)
        par_pulse();
        `PCC_CHK(perr_oe, 1'b0)
        `PCC_CHK(perr_o, 1'b0)
        rd_chk(8'h06, 16'h8000);
        @(posedge ref_clk);
        ad_out <= 32'h0000_0003;
        cbe_out <= 4'h1;
        ad_drive <= 1'b1;
        step(1);
        `PCC_CHK(par_o, 1'b1)
        `PCC_CHK(par_oe, 1'b1)
        @(posedge ref_clk);
        ad_drive <= 1'b0;
        $display("test all bits clear done");
        complete_run();
    end
endmodule // pci_command_ctrl_bits_test
